// File: core/dmd_regs.svh
// Purpose: constants for the data move decoder
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file address
// Notes: one instruction cycle is four quarter-cycles
`ifndef DMD_REGS_SVH
`define DMD_REGS_SVH
`define DMD_LIT_MASK 14'h3c00
`define DMD_LIT_MATCH 14'h3000
`define DMD_CPY_MASK 14'h3f00
`define DMD_CPY_MATCH 14'h0800
`define DMD_STO_MASK 14'h3f80
`define DMD_STO_MATCH 14'h0080
`define DMD_IDLE_MASK 14'h3f9f
`define DMD_IDLE_MATCH 14'h0000
`define DMD_DEST_BIT 7
`define DMD_W_RST 8'h00
`define DMD_Z_RST 1'h0
`endif

// File: core/dmd_pkg.sv
// Purpose: types for the data move decoder
// Assumes: constants live in dmd_regs.svh
// Notes: none
package dmd_pkg;
	typedef enum logic [3:0] {
		DMD_Q1 = 4'h1,
		DMD_Q2 = 4'h2,
		DMD_Q3 = 4'h4,
		DMD_Q4 = 4'h8
	} dmd_quarter_t;
	typedef enum logic [4:0] {
		DMD_OP_LOAD_LITERAL_TO_ACCUMULATOR = 5'h01,
		DMD_OP_COPY_FILE_REGISTER = 5'h02,
		DMD_OP_STORE_ACCUMULATOR_TO_FILE = 5'h04,
		DMD_OP_IDLE_INSTRUCTION = 5'h08,
		DMD_OP_OTHER = 5'h10
	} dmd_op_t;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [6:0] addr;
		logic [7:0] wdata;
	} dmd_file_t;
endpackage

// File: core/dmd_decode.sv
// Purpose: classify a fetched word into one of the handled instructions
// Assumes: word is stable during the instruction cycle
// Notes: combinational
`timescale 1ns/1ps
`include "dmd_regs.svh"
module dmd_decode (
	input wire logic [13:0] i_word,
	output dmd_pkg::dmd_op_t o_op
);
	import dmd_pkg::*;
	always_comb
	begin
		if ((i_word & `DMD_LIT_MASK) == `DMD_LIT_MATCH)
			o_op = DMD_OP_LOAD_LITERAL_TO_ACCUMULATOR;
		else if ((i_word & `DMD_CPY_MASK) == `DMD_CPY_MATCH)
			o_op = DMD_OP_COPY_FILE_REGISTER;
		else if ((i_word & `DMD_STO_MASK) == `DMD_STO_MATCH)
			o_op = DMD_OP_STORE_ACCUMULATOR_TO_FILE;
		else if ((i_word & `DMD_IDLE_MASK) == `DMD_IDLE_MATCH)
			o_op = DMD_OP_IDLE_INSTRUCTION;
		else
			o_op = DMD_OP_OTHER;
	end
endmodule // dmd_decode

// File: core/dmd_core.sv
// Purpose: decode and execute four data move instructions
// Assumes: file register read data is valid the edge after o_file.rd
// Notes: unknown words run as idle cycles
// Behaviour
// - Literal load puts eight bits into accumulator; x bits ignored; flags kept.
// - Copy with destination 0 writes file register value into accumulator.
// - Copy with destination 1 writes value back to same file register.
// - Copy sets zero flag when moved value is zero, clears otherwise.
// - Copy: decode, read, process, write across quarters one to four.
// - Idle word changes no register, memory or flag.
// - Idle takes one cycle; only decode quarter active.
`timescale 1ns/1ps
`include "dmd_regs.svh"
module dmd_core (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [13:0] i_word,
	input wire logic [7:0] i_file_rdata,
	output dmd_pkg::dmd_file_t o_file,
	output logic [7:0] o_acc,
	output logic o_zero,
	output logic o_cycle_done,
	output dmd_pkg::dmd_quarter_t o_quarter
);
	import dmd_pkg::*;
	dmd_quarter_t q_q;
	dmd_op_t op_q;
	dmd_op_t op_dec;
	logic [13:0] word_q;
	logic [7:0] data_q;
	logic [7:0] acc_q;
	logic zero_q;
	dmd_file_t file_q;
	logic done_q;

	dmd_decode u_decode (
		.i_word(i_word),
		.o_op(op_dec)
	);

	// Quarter sequencer
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			q_q <= DMD_Q1;
		else
		begin
			unique case (q_q)
				DMD_Q1: q_q <= DMD_Q2;
				DMD_Q2: q_q <= DMD_Q3;
				DMD_Q3: q_q <= DMD_Q4;
				DMD_Q4: q_q <= DMD_Q1;
			endcase
		end
	end

	// Decode quarter latches word
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			op_q <= DMD_OP_IDLE_INSTRUCTION;
			word_q <= 14'h0000;
		end
		else if (q_q == DMD_Q1)
		begin
			op_q <= op_dec;
			word_q <= i_word;
		end
	end

	// File bus strobes
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			file_q <= '0;
		else
		begin
			file_q.rd <= 1'b0;
			file_q.wr <= 1'b0;
			unique case (q_q)
				DMD_Q1:
				begin
					// Read issued in second quarter
					if (op_dec == DMD_OP_COPY_FILE_REGISTER)
					begin
						file_q.rd <= 1'b1;
						file_q.addr <= i_word[6:0];
					end
				end
				DMD_Q3:
				begin
					if (op_q == DMD_OP_COPY_FILE_REGISTER
						&& word_q[`DMD_DEST_BIT])
					begin
						file_q.wr <= 1'b1;
						file_q.addr <= word_q[6:0];
						// Fresh read data; data_q lands at this same edge
						file_q.wdata <= i_file_rdata;
					end
					else if (op_q == DMD_OP_STORE_ACCUMULATOR_TO_FILE)
					begin
						file_q.wr <= 1'b1;
						file_q.addr <= word_q[6:0];
						file_q.wdata <= acc_q;
					end
				end
				default:
				begin
				end
			endcase
		end
	end

	// Capture read data in third quarter
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			data_q <= 8'h00;
		else if (q_q == DMD_Q3 && op_q == DMD_OP_COPY_FILE_REGISTER)
			data_q <= i_file_rdata;
	end

	// Accumulator written in fourth quarter
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			acc_q <= `DMD_W_RST;
		else if (q_q == DMD_Q4)
		begin
			if (op_q == DMD_OP_LOAD_LITERAL_TO_ACCUMULATOR)
				acc_q <= word_q[7:0];
			else if (op_q == DMD_OP_COPY_FILE_REGISTER
				&& !word_q[`DMD_DEST_BIT])
				acc_q <= data_q;
		end
	end

	// Zero flag, copy only
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			zero_q <= `DMD_Z_RST;
		else if (q_q == DMD_Q4 && op_q == DMD_OP_COPY_FILE_REGISTER)
			zero_q <= (data_q == 8'h00);
	end

	// End of cycle pulse; idle does nothing else
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			done_q <= 1'b0;
		else
			done_q <= (q_q == DMD_Q4);
	end

	assign o_file = file_q;
	assign o_acc = acc_q;
	assign o_zero = zero_q;
	assign o_cycle_done = done_q;
	assign o_quarter = q_q;
endmodule // dmd_core

// File: testbench/dmd_checker.sv
// Purpose: checks on dmd_core
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ps
module dmd_checker (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [13:0] i_word,
	input wire logic [7:0] i_file_rdata,
	input dmd_pkg::dmd_file_t o_file,
	input wire logic [7:0] o_acc,
	input wire logic o_zero,
	input wire logic o_cycle_done,
	input dmd_pkg::dmd_quarter_t o_quarter
);
	import dmd_pkg::*;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	wire q1 = o_quarter == DMD_Q1;
	wire [13:0] w = i_word;
	wire [7:0] d = i_file_rdata;
	sequence s_walk;
		o_quarter == DMD_Q2 ##1 o_quarter == DMD_Q3 ##1 o_quarter == DMD_Q4;
	endsequence
	a_quarter_walk: assert property (q1 |=> s_walk ##1 q1 && o_cycle_done)
		else $error("quarter order");
	a_lit_load: assert property (q1 && w[13:10] == 4'hc |-> ##4
		o_acc == $past(w[7:0], 4) && $stable(o_zero)) else $error("literal");
	a_copy_read: assert property (q1 && w[13:8] == 6'h08 |-> ##1
		o_file.rd && o_file.addr == $past(w[6:0])) else $error("read");
	a_copy_acc: assert property (q1 && w[13:7] == 7'h10 |-> ##4
		o_acc == $past(d, 2)) else $error("copy to acc");
	a_copy_back: assert property (q1 && w[13:7] == 7'h11 |-> ##3
		o_file.wr && o_file.wdata == $past(d) ##1 $stable(o_acc))
		else $error("copy back");
	a_copy_zero: assert property (q1 && w[13:8] == 6'h08 |-> ##4
		o_zero == ($past(d, 2) == 8'h00)) else $error("zero flag");
	a_store_write: assert property (q1 && w[13:7] == 7'h01 |-> ##3
		o_file.wr && o_file.wdata == o_acc ##1 $stable(o_zero))
		else $error("store");
	a_idle_quiet: assert property (q1 && (w & 14'h3f9f) == 0 |->
		(!o_file.rd && !o_file.wr)[*4] ##0 $stable(o_acc) && $stable(o_zero))
		else $error("idle");
endmodule // dmd_checker
bind dmd_core dmd_checker dmd_checker_inst (.i_clk_sys(i_clk_sys),
	.i_rst(i_rst), .i_word(i_word), .i_file_rdata(i_file_rdata),
	.o_file(o_file), .o_acc(o_acc), .o_zero(o_zero),
	.o_cycle_done(o_cycle_done), .o_quarter(o_quarter));

// File: testbench/tb.sv
// Purpose: bench for dmd_core
// Assumes: inputs change at falling edge
// Notes: back to back words
`timescale 1ns/1ps
module tb;
	import dmd_pkg::*;
	logic i_clk_sys = 0;
	logic i_rst = 1;
	logic [13:0] i_word = 0;
	logic [7:0] i_file_rdata = 0;
	dmd_file_t o_file;
	logic [7:0] o_acc, wd;
	logic o_zero, o_cycle_done;
	dmd_quarter_t o_quarter;
	logic [2:0] rd_n, wr_n;
	logic [6:0] wa;
	int fails = 0, n_compared = 0;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
	$display("Error %0t %h %h", $time, a, e); end end
	always #5 i_clk_sys = ~i_clk_sys;
	dmd_core dmd_core_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_word(i_word), .i_file_rdata(i_file_rdata), .o_file(o_file),
		.o_acc(o_acc), .o_zero(o_zero), .o_cycle_done(o_cycle_done),
		.o_quarter(o_quarter));
	task op(input logic [13:0] w, input logic [7:0] d);
		while (o_quarter !== DMD_Q1) @(negedge i_clk_sys);
		i_word = w;
		i_file_rdata = d;
		rd_n = 0;
		wr_n = 0;
		repeat (4)
		begin
			@(negedge i_clk_sys);
			rd_n += o_file.rd;
			wr_n += o_file.wr;
			if (o_quarter === DMD_Q4)
			begin
				wd = o_file.wdata;
				wa = o_file.addr;
			end
		end
	endtask
	task t_literal;
		op(14'h335a, 8'h00);
		`CHK({o_acc, o_zero}, {8'h5a, 1'b0})
		op(14'h3000, 8'hff);
		`CHK(o_acc, 8'h00)
	endtask
	task t_copy;
		op(14'h0805, 8'h00);
		`CHK({rd_n, wr_n, o_acc, o_zero}, {3'h1, 3'h0, 9'h001})
		op(14'h087f, 8'h81);
		`CHK({o_acc, o_zero}, {8'h81, 1'b0})
		op(14'h3033, 8'h00);
		op(14'h08aa, 8'h00);
		`CHK({wr_n, wd, wa, o_acc, o_zero}, {3'h1, 15'h002a, 9'h067})
	endtask
	task t_store;
		op(14'h00c4, 8'h5a);
		`CHK({wr_n, wd, wa, o_zero}, {3'h1, 8'h33, 7'h44, 1'b1})
	endtask
	task t_idle;
		op(14'h0060, 8'h00);
		`CHK({rd_n, wr_n, o_acc, o_zero}, {6'h00, 9'h067})
		`CHK({o_cycle_done, o_quarter}, {1'b1, 4'h1})
	endtask
	task complete_run;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(negedge i_clk_sys);
		i_rst = 0;
		t_literal;
		t_copy;
		t_store;
		t_idle;
		complete_run;
	end
	initial
	begin
		#20000;
		fails++;
		complete_run;
	end
endmodule // tb
